// ===== rtl/ces_pkg.sv
package ces_pkg;

  // ==========================================================
  // Sizes, opcodes and addressing modes
  // ==========================================================
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } ces_size_t;

  typedef enum logic [3:0] {
    IDLE_OP = 4'h0,
    SYS_OP = 4'h1,
    FLAGS_LOGIC_OP = 4'h2,
    FLAGS_LOAD_REG_OP = 4'h3,
    FLAGS_STORE_REG_OP = 4'h4,
    FLAGS_LOAD_OP = 4'h5,
    FLAGS_STORE_OP = 4'h6,
    MOV_LOAD_OP = 4'h7,
    MOV_STORE_OP = 4'h8,
    MOV_IMM_OP = 4'h9,
    BIT_REG_OP = 4'ha,
    BIT_IND_OP = 4'hb,
    BIT_ABS_OP = 4'hc,
    BLOCK_MOVE_OP = 4'hd,
    ADD_OP = 4'he
  } ces_op_t;

  typedef enum logic [2:0] {
    EA_IND = 3'h0,
    EA_DISP16 = 3'h1,
    EA_DISP24 = 3'h2,
    EA_POSTINC = 3'h3,
    EA_PREDEC = 3'h4,
    EA_ABS8 = 3'h5,
    EA_ABS16 = 3'h6,
    EA_ABS24 = 3'h7
  } ces_ea_t;

  typedef enum logic [2:0] {
    BIT_SET_OP = 3'h0,
    BIT_CLEAR_OP = 3'h1,
    BIT_INVERT_OP = 3'h2,
    CARRY_TO_BIT_OP = 3'h3,
    INV_CARRY_TO_BIT_OP = 3'h4,
    BIT_TEST_OP = 3'h5
  } ces_bitop_t;

  // System and flag-logic sub codes
  localparam logic [3:0] SOFTWARE_TRAP_OP = 4'h0;
  localparam logic [3:0] EXCEPTION_RETURN_OP = 4'h1;
  localparam logic [3:0] SLEEP_OP = 4'h2;
  localparam logic [3:0] FLAGS_AND_OP = 4'h0;
  localparam logic [3:0] FLAGS_OR_OP = 4'h1;
  localparam logic [3:0] FLAGS_XOR_OP = 4'h2;

  // ==========================================================
  // Flag layout, reset values, constants
  // ==========================================================
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h80;
  localparam logic [23:0] RESET_PC_DEF = 24'h000100;
  localparam logic [23:0] TRAP_VEC_BASE_DEF = 24'h000020;
  localparam logic [23:0] INSN_BYTES = 24'h000002;
  localparam logic [15:0] ABS8_FILL = 16'hffff;
  localparam logic [7:0] ADDR_TOP_ZERO = 8'h00;
  localparam logic [2:0] WORD_COUNT_REG = 3'h4;
  localparam logic [3:0] BYTE_COUNT_SEL = 4'hc;
  localparam logic [3:0] WORD_COUNT_SEL = 4'h4;
  localparam logic [2:0] SOURCE_POINTER_REG = 3'h5;
  localparam logic [2:0] DEST_POINTER_REG = 3'h6;

  typedef struct packed {
    logic req;
    logic we;
    ces_size_t size;
    logic [23:0] addr;
    logic [31:0] wdata;
  } ces_bus_t;

  // ==========================================================
  // Shared helpers
  // ==========================================================
  function automatic logic [23:0] ces_addr_fix(logic [31:0] a, ces_size_t sz, logic mb1);
    logic [23:0] r;
    r = a[23:0];
    if (mb1) begin
      r[23:20] = 4'h0;
    end
    if (sz != SZ_BYTE) begin
      r[0] = 1'b0;
    end
    return r;
  endfunction

  function automatic ces_bus_t ces_cmd(logic we, ces_size_t sz, logic [23:0] a, logic [31:0] d);
    ces_bus_t b;
    b.req = 1'b1;
    b.we = we;
    b.size = sz;
    b.addr = a;
    b.wdata = d;
    return b;
  endfunction

endpackage

// ===== rtl/ces_ea_unit.sv
`timescale 1ns/1ps
module ces_ea_unit import ces_pkg::*; (
  // Operand description
  input wire ces_ea_t mode_i,
  input wire ces_size_t size_i,
  input wire logic [31:0] areg_i,
  input wire logic [31:0] ext_i,
  input wire logic mb1_i,
  // Results
  output logic [23:0] addr_o,
  output logic wb_o,
  output logic [31:0] wb_val_o
);
  logic [31:0] step;
  logic [31:0] ea;

  assign step = (size_i == SZ_LONG) ? 32'h4 : (size_i == SZ_WORD) ? 32'h2 : 32'h1;

  always_comb begin
    ea = areg_i;
    wb_o = 1'b0;
    wb_val_o = areg_i;
    case (mode_i)
      EA_IND: ea = areg_i;
      EA_DISP16: ea = areg_i + {{16{ext_i[15]}}, ext_i[15:0]};
      EA_DISP24: ea = areg_i + {ADDR_TOP_ZERO, ext_i[23:0]};
      EA_POSTINC: begin
        wb_o = 1'b1;
        wb_val_o = areg_i + step;
      end
      EA_PREDEC: begin
        wb_o = 1'b1;
        wb_val_o = areg_i - step;
        ea = areg_i - step;
      end
      EA_ABS8: ea = {ADDR_TOP_ZERO, ABS8_FILL, ext_i[7:0]};
      EA_ABS16: ea = {{16{ext_i[15]}}, ext_i[15:0]};
      EA_ABS24: ea = {ADDR_TOP_ZERO, ext_i[23:0]};
      default: ea = areg_i;
    endcase
  end

  assign addr_o = ces_addr_fix(ea, size_i, mb1_i);

endmodule // ces_ea_unit

// ===== rtl/ces_bit_alu.sv
`timescale 1ns/1ps
module ces_bit_alu import ces_pkg::*; (
  // Operation
  input wire ces_bitop_t op_i,
  input wire logic [7:0] byte_i,
  input wire logic [2:0] bit_i,
  input wire logic carry_i,
  // Result
  output logic [7:0] byte_o,
  output logic wr_o,
  output logic zero_o
);
  always_comb begin
    byte_o = byte_i;
    wr_o = 1'b1;
    zero_o = ~byte_i[bit_i];
    case (op_i)
      BIT_SET_OP: byte_o[bit_i] = 1'b1;
      BIT_CLEAR_OP: byte_o[bit_i] = 1'b0;
      BIT_INVERT_OP: byte_o[bit_i] = ~byte_i[bit_i];
      CARRY_TO_BIT_OP: byte_o[bit_i] = carry_i;
      INV_CARRY_TO_BIT_OP: byte_o[bit_i] = ~carry_i;
      default: wr_o = 1'b0;
    endcase
  end

endmodule // ces_bit_alu

// ===== rtl/ces_top.sv
`timescale 1ns/1ps
module ces_top import ces_pkg::*; #(
  parameter logic [23:0] RESET_PC = RESET_PC_DEF,
  parameter logic [23:0] TRAP_VEC_BASE = TRAP_VEC_BASE_DEF
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Memory and peripheral bus
  output ces_bus_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // Pins
  input wire logic mode_1mb_i,
  input wire logic wake_i,
  // Status
  output logic [23:0] pc_o,
  output logic [7:0] flags_o,
  output logic sleep_o,
  output logic trap_o,
  output logic rte_o,
  output logic illegal_o,
  // Register observation
  input wire logic [2:0] dbg_sel_i,
  output logic [31:0] dbg_data_o
);

  // ==========================================================
  // State
  // ==========================================================
  typedef enum logic [3:0] {
    S_FETCH = 4'h0,
    S_EXT = 4'h1,
    S_EXEC = 4'h2,
    S_MEM = 4'h3,
    S_MEM2 = 4'h4,
    S_BM_CHECK = 4'h5,
    S_BM_RD = 4'h6,
    S_BM_WR = 4'h7,
    S_VEC = 4'h8,
    S_SLEEP = 4'h9
  } ces_state_t;

  ces_state_t state_q, state_d;
  ces_bus_t bus_q, bus_d;
  logic [23:0] pc_q, pc_d, vec_q, vec_d, shpc_q, shpc_d;
  logic [7:0] flags_q, flags_d, shfl_q, shfl_d, tmp_q, tmp_d;
  logic [15:0] word0_q, word0_d;
  logic [31:0] ext_q, ext_d, dbg_q, dbg_d;
  logic [1:0] extn_q, extn_d, mode_sync_q, mode_sync_d, wake_sync_q, wake_sync_d;
  logic sleep_q, sleep_d, trap_q, trap_d, rte_q, rte_d, ill_q, ill_d;
  logic [31:0] regs_q [8];
  logic wa_en, wb_en;
  logic [2:0] wa_idx, wb_idx;
  logic [31:0] wa_val, wb_val;

  // ==========================================================
  // Decode helpers
  // ==========================================================
  function automatic logic [31:0] sized_read(logic [31:0] v, logic [3:0] sel, ces_size_t sz);
    case (sz)
      SZ_BYTE: return {24'h0, sel[3] ? v[7:0] : v[15:8]};
      SZ_WORD: return {16'h0, sel[3] ? v[31:16] : v[15:0]};
      default: return v;
    endcase
  endfunction

  function automatic logic [31:0] sized_merge(logic [31:0] v, logic [3:0] sel, ces_size_t sz,
                                              logic [31:0] nv);
    logic [31:0] r;
    r = v;
    case (sz)
      SZ_BYTE: if (sel[3]) r[7:0] = nv[7:0]; else r[15:8] = nv[7:0];
      SZ_WORD: if (sel[3]) r[31:16] = nv[15:0]; else r[15:0] = nv[15:0];
      default: r = nv;
    endcase
    return r;
  endfunction

  function automatic logic [1:0] ext_words(logic [15:0] w);
    logic [1:0] n;
    n = 2'h0;
    case (ces_op_t'(w[15:12]))
      FLAGS_LOAD_OP, FLAGS_STORE_OP, MOV_LOAD_OP, MOV_STORE_OP: begin
        case (ces_ea_t'(w[11:9]))
          EA_DISP16, EA_ABS8, EA_ABS16: n = 2'h1;
          EA_DISP24, EA_ABS24: n = 2'h2;
          default: n = 2'h0;
        endcase
      end
      MOV_IMM_OP: n = 2'h2;
      BIT_ABS_OP: n = 2'h1;
      ADD_OP: n = {1'b0, w[8]};
      default: n = 2'h0;
    endcase
    return n;
  endfunction

  ces_op_t op;
  logic [3:0] sub, ra, rb;
  logic [31:0] rd_a, rd_b, cnt;
  ces_size_t mem_sz, mov_sz, cnt_sz;
  ces_ea_t ea_mode;
  logic [23:0] ea_addr;
  logic ea_wb, mb1, wake_s, alu_wr, alu_zero;
  logic [31:0] ea_wb_val;
  logic [7:0] bit_src, alu_in, alu_out;
  logic [15:0] dst16, src16;
  logic [16:0] sum17;

  assign op = ces_op_t'(word0_q[15:12]);
  assign sub = word0_q[11:8];
  assign ra = word0_q[7:4];
  assign rb = word0_q[3:0];
  assign rd_a = regs_q[ra[2:0]];
  assign rd_b = regs_q[rb[2:0]];
  assign mb1 = mode_sync_q[1];
  assign wake_s = wake_sync_q[1];
  assign mov_sz = ces_size_t'({sub[0], ra[3]});
  assign mem_sz = (op == FLAGS_LOAD_OP || op == FLAGS_STORE_OP) ? SZ_WORD :
                  (op == BIT_IND_OP || op == BIT_ABS_OP) ? SZ_BYTE : mov_sz;
  assign ea_mode = (op == BIT_IND_OP) ? EA_IND : (op == BIT_ABS_OP) ? EA_ABS8 :
                   ces_ea_t'(sub[3:1]);
  assign cnt_sz = sub[0] ? SZ_WORD : SZ_BYTE;
  assign cnt = sized_read(regs_q[WORD_COUNT_REG], sub[0] ? WORD_COUNT_SEL : BYTE_COUNT_SEL,
                          cnt_sz);
  assign dst16 = rd_b[15:0];
  assign src16 = sub[0] ? ext_q[15:0] : 16'(sized_read(rd_a, ra, SZ_WORD));
  assign sum17 = {1'b0, 16'(sized_read(rd_b, rb, SZ_WORD))} + {1'b0, src16};
  assign bit_src = 8'(sized_read(rd_a, ra, SZ_BYTE));
  assign alu_in = (state_q == S_EXEC) ? 8'(sized_read(rd_b, rb, SZ_BYTE)) : tmp_q;

  ces_ea_unit u_ea (
    .mode_i(ea_mode),
    .size_i(mem_sz),
    .areg_i(op == BIT_IND_OP ? rd_b : rd_a),
    .ext_i(ext_q),
    .mb1_i(mb1),
    .addr_o(ea_addr),
    .wb_o(ea_wb),
    .wb_val_o(ea_wb_val)
  );

  ces_bit_alu u_bit (
    .op_i(ces_bitop_t'(sub[3:1])),
    .byte_i(alu_in),
    .bit_i(sub[0] ? bit_src[2:0] : ra[2:0]),
    .carry_i(flags_q[FLAG_C]),
    .byte_o(alu_out),
    .wr_o(alu_wr),
    .zero_o(alu_zero)
  );

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_comb begin
    state_d = state_q;
    bus_d = bus_q;
    pc_d = pc_q;
    vec_d = vec_q;
    shpc_d = shpc_q;
    shfl_d = shfl_q;
    flags_d = flags_q;
    tmp_d = tmp_q;
    word0_d = word0_q;
    ext_d = ext_q;
    extn_d = extn_q;
    sleep_d = sleep_q;
    trap_d = 1'b0;
    rte_d = 1'b0;
    ill_d = 1'b0;
    wa_en = 1'b0;
    wa_idx = 3'h0;
    wa_val = 32'h0;
    wb_en = 1'b0;
    wb_idx = 3'h0;
    wb_val = 32'h0;
    mode_sync_d = {mode_sync_q[0], mode_1mb_i};
    wake_sync_d = {wake_sync_q[0], wake_i};
    dbg_d = regs_q[dbg_sel_i];
    // Every access drops its request for one cycle after the ack
    if (bus_q.req && mem_ack_i) begin
      bus_d.req = 1'b0;
    end
    case (state_q)
      S_FETCH: begin
        if (!bus_q.req) begin
          bus_d = ces_cmd(1'b0, SZ_WORD, ces_addr_fix({8'h0, pc_q}, SZ_WORD, mb1), 32'h0);
        end else if (mem_ack_i) begin
          word0_d = mem_rdata_i[15:0];
          pc_d = pc_q + INSN_BYTES;
          ext_d = 32'h0;
          extn_d = ext_words(mem_rdata_i[15:0]);
          state_d = (ext_words(mem_rdata_i[15:0]) == 2'h0) ? S_EXEC : S_EXT;
        end
      end
      S_EXT: begin
        if (!bus_q.req) begin
          bus_d = ces_cmd(1'b0, SZ_WORD, ces_addr_fix({8'h0, pc_q}, SZ_WORD, mb1), 32'h0);
        end else if (mem_ack_i) begin
          ext_d = {ext_q[15:0], mem_rdata_i[15:0]};
          pc_d = pc_q + INSN_BYTES;
          extn_d = extn_q - 2'h1;
          state_d = (extn_q == 2'h1) ? S_EXEC : S_EXT;
        end
      end
      S_EXEC: begin
        state_d = S_FETCH;
        case (op)
          IDLE_OP: state_d = S_FETCH;
          SYS_OP: begin
            if (sub == SOFTWARE_TRAP_OP) begin
              shpc_d = pc_q;
              shfl_d = flags_q;
              flags_d[FLAG_I] = 1'b1;
              vec_d = TRAP_VEC_BASE + {20'h0, word0_q[1:0], 2'h0};
              trap_d = 1'b1;
              state_d = S_VEC;
            end else if (sub == EXCEPTION_RETURN_OP) begin
              pc_d = shpc_q;
              flags_d = shfl_q;
              rte_d = 1'b1;
            end else if (sub == SLEEP_OP) begin
              sleep_d = 1'b1;
              state_d = S_SLEEP;
            end else begin
              ill_d = 1'b1;
            end
          end
          FLAGS_LOGIC_OP: begin
            case (sub)
              FLAGS_AND_OP: flags_d = flags_q & word0_q[7:0];
              FLAGS_OR_OP: flags_d = flags_q | word0_q[7:0];
              FLAGS_XOR_OP: flags_d = flags_q ^ word0_q[7:0];
              default: ill_d = 1'b1;
            endcase
          end
          FLAGS_LOAD_REG_OP: flags_d = 8'(sized_read(rd_b, rb, SZ_BYTE));
          FLAGS_STORE_REG_OP: begin
            wb_en = 1'b1;
            wb_idx = rb[2:0];
            wb_val = sized_merge(rd_b, rb, SZ_BYTE, {24'h0, flags_q});
          end
          FLAGS_LOAD_OP, FLAGS_STORE_OP, BIT_IND_OP, BIT_ABS_OP: state_d = S_MEM;
          MOV_LOAD_OP, MOV_STORE_OP: begin
            if (mov_sz == SZ_BYTE || mov_sz == SZ_WORD || mov_sz == SZ_LONG) begin
              state_d = S_MEM;
            end else begin
              ill_d = 1'b1;
            end
          end
          MOV_IMM_OP: begin
            wb_en = 1'b1;
            wb_idx = rb[2:0];
            wb_val = ext_q;
          end
          BIT_REG_OP: begin
            flags_d[FLAG_Z] = alu_wr ? flags_q[FLAG_Z] : alu_zero;
            wb_en = alu_wr;
            wb_idx = rb[2:0];
            wb_val = sized_merge(rd_b, rb, SZ_BYTE, {24'h0, alu_out});
          end
          BLOCK_MOVE_OP: state_d = S_BM_CHECK;
          ADD_OP: begin
            wb_en = 1'b1;
            wb_idx = rb[2:0];
            wb_val = sized_merge(rd_b, rb, SZ_WORD, {16'h0, sum17[15:0]});
            flags_d[FLAG_C] = sum17[16];
            flags_d[FLAG_N] = sum17[15];
            flags_d[FLAG_Z] = (sum17[15:0] == 16'h0);
          end
          default: ill_d = 1'b1;
        endcase
      end
      S_MEM: begin
        if (!bus_q.req) begin
          bus_d = ces_cmd(op == FLAGS_STORE_OP || op == MOV_STORE_OP, mem_sz, ea_addr,
                          op == FLAGS_STORE_OP ? {16'h0, flags_q, 8'h0} :
                          sized_read(rd_b, rb, mem_sz));
        end else if (mem_ack_i) begin
          wa_en = ea_wb;
          wa_idx = ra[2:0];
          wa_val = ea_wb_val;
          tmp_d = mem_rdata_i[7:0];
          state_d = (op == BIT_IND_OP || op == BIT_ABS_OP) ? S_MEM2 : S_FETCH;
          if (op == FLAGS_LOAD_OP) begin
            flags_d = mem_rdata_i[15:8];
          end
          if (op == MOV_LOAD_OP) begin
            wb_en = 1'b1;
            wb_idx = rb[2:0];
            wb_val = sized_merge(rd_b, rb, mem_sz, mem_rdata_i);
          end
        end
      end
      S_MEM2: begin
        if (!alu_wr) begin
          flags_d[FLAG_Z] = alu_zero;
          state_d = S_FETCH;
        end else if (!bus_q.req) begin
          bus_d = ces_cmd(1'b1, SZ_BYTE, ea_addr, {24'h0, alu_out});
        end else if (mem_ack_i) begin
          state_d = S_FETCH;
        end
      end
      S_BM_CHECK: state_d = (cnt == 32'h0) ? S_FETCH : S_BM_RD;
      S_BM_RD: begin
        if (!bus_q.req) begin
          bus_d = ces_cmd(1'b0, SZ_BYTE, ces_addr_fix(regs_q[SOURCE_POINTER_REG], SZ_BYTE, mb1),
                          32'h0);
        end else if (mem_ack_i) begin
          tmp_d = mem_rdata_i[7:0];
          wa_en = 1'b1;
          wa_idx = SOURCE_POINTER_REG;
          wa_val = regs_q[SOURCE_POINTER_REG] + 32'h1;
          state_d = S_BM_WR;
        end
      end
      S_BM_WR: begin
        if (!bus_q.req) begin
          bus_d = ces_cmd(1'b1, SZ_BYTE, ces_addr_fix(regs_q[DEST_POINTER_REG], SZ_BYTE, mb1),
                          {24'h0, tmp_q});
        end else if (mem_ack_i) begin
          wa_en = 1'b1;
          wa_idx = DEST_POINTER_REG;
          wa_val = regs_q[DEST_POINTER_REG] + 32'h1;
          wb_en = 1'b1;
          wb_idx = WORD_COUNT_REG;
          wb_val = sized_merge(regs_q[WORD_COUNT_REG], sub[0] ? WORD_COUNT_SEL : BYTE_COUNT_SEL,
                               cnt_sz, cnt - 32'h1);
          state_d = S_BM_CHECK;
        end
      end
      S_VEC: begin
        if (!bus_q.req) begin
          bus_d = ces_cmd(1'b0, SZ_LONG, ces_addr_fix({8'h0, vec_q}, SZ_LONG, mb1), 32'h0);
        end else if (mem_ack_i) begin
          pc_d = ces_addr_fix(mem_rdata_i, SZ_WORD, mb1);
          state_d = S_FETCH;
        end
      end
      S_SLEEP: begin
        if (wake_s) begin
          sleep_d = 1'b0;
          state_d = S_FETCH;
        end
      end
      default: state_d = S_FETCH;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= S_FETCH;
      bus_q <= '0;
      pc_q <= RESET_PC;
      vec_q <= 24'h0;
      shpc_q <= 24'h0;
      shfl_q <= FLAGS_RESET;
      flags_q <= FLAGS_RESET;
      tmp_q <= 8'h0;
      word0_q <= 16'h0;
      ext_q <= 32'h0;
      extn_q <= 2'h0;
      sleep_q <= 1'b0;
      trap_q <= 1'b0;
      rte_q <= 1'b0;
      ill_q <= 1'b0;
      mode_sync_q <= 2'h0;
      wake_sync_q <= 2'h0;
      dbg_q <= 32'h0;
    end else begin
      state_q <= state_d;
      bus_q <= bus_d;
      pc_q <= pc_d;
      vec_q <= vec_d;
      shpc_q <= shpc_d;
      shfl_q <= shfl_d;
      flags_q <= flags_d;
      tmp_q <= tmp_d;
      word0_q <= word0_d;
      ext_q <= ext_d;
      extn_q <= extn_d;
      sleep_q <= sleep_d;
      trap_q <= trap_d;
      rte_q <= rte_d;
      ill_q <= ill_d;
      mode_sync_q <= mode_sync_d;
      wake_sync_q <= wake_sync_d;
      dbg_q <= dbg_d;
    end
  end

  // ==========================================================
  // Register file
  // ==========================================================
  // Port b wins on a clash: loaded data beats a pointer update
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= 32'h0;
      end
    end else begin
      if (wa_en) begin
        regs_q[wa_idx] <= wa_val;
      end
      if (wb_en) begin
        regs_q[wb_idx] <= wb_val;
      end
    end
  end

  assign mem_o = bus_q;
  assign pc_o = pc_q;
  assign flags_o = flags_q;
  assign sleep_o = sleep_q;
  assign trap_o = trap_q;
  assign rte_o = rte_q;
  assign illegal_o = ill_q;
  assign dbg_data_o = dbg_q;

endmodule // ces_top

// ===== bench/ces_top_sva.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the core
module ces_top_sva import ces_pkg::*; #(
  parameter logic [23:0] RESET_PC = RESET_PC_DEF,
  parameter logic [23:0] TRAP_VEC_BASE = TRAP_VEC_BASE_DEF
) (
  // Watched ports
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire ces_bus_t mem_o,
  input wire logic mem_ack_i,
  input wire logic mode_1mb_i,
  input wire logic wake_i,
  input wire logic [23:0] pc_o,
  input wire logic [7:0] flags_o,
  input wire logic sleep_o,
  input wire logic trap_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  property p_hold; mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o); endproperty
  a_hold: assert property (p_hold)
    else $error("bus request changed before ack");
  property p_drop; mem_o.req && mem_ack_i |=> !mem_o.req; endproperty
  a_drop: assert property (p_drop)
    else $error("request not dropped after ack");
  property p_even; mem_o.req && mem_o.size != SZ_BYTE |-> !mem_o.addr[0]; endproperty
  a_even: assert property (p_even)
    else $error("odd address on word or long access");
  property p_mb; mode_1mb_i [*4] ##0 mem_o.req |-> mem_o.addr[23:20] == 4'h0; endproperty
  a_mb: assert property (p_mb)
    else $error("upper address bits set in small mode");
  property p_trap; trap_o |=> !trap_o ##[0:3] flags_o[FLAG_I]; endproperty
  a_trap: assert property (p_trap)
    else $error("trap pulse or interrupt mask wrong");
  property p_nap; (!wake_i) [*4] ##0 sleep_o |=> sleep_o; endproperty
  a_nap: assert property (p_nap)
    else $error("left power-down without wake");
  property p_quiet; sleep_o |-> !mem_o.req; endproperty
  a_quiet: assert property (p_quiet)
    else $error("bus access while in power-down");
  property p_rst;
    $fell(reset_i) |-> pc_o == RESET_PC && flags_o == FLAGS_RESET
      ##1 mem_o.req && mem_o.addr == RESET_PC;
  endproperty
  a_rst: assert property (p_rst)
    else $error("first fetch after reset wrong");

  c_trap: cover property (trap_o);
  c_nap: cover property ($rose(sleep_o));
  c_wait: cover property (mem_o.req && !mem_ack_i ##1 mem_ack_i);
  c_long: cover property (mem_o.req && mem_o.we && mem_o.size == SZ_LONG);
endmodule // ces_top_sva

bind ces_top ces_top_sva #(.RESET_PC(RESET_PC), .TRAP_VEC_BASE(TRAP_VEC_BASE)) u_sva (
  .sys_clk_i, .reset_i, .mem_o, .mem_ack_i, .mode_1mb_i, .wake_i, .pc_o, .flags_o,
  .sleep_o, .trap_o);

// ===== bench/ces_mem_model.sv
`timescale 1ns/1ps
// ==========================================================
// Byte memory, big-endian, 4 KiB image
module ces_mem_model import ces_pkg::*; (
  // Bus side
  input wire logic clk_i,
  input wire ces_bus_t bus_i,
  input wire logic [1:0] wait_i,
  output logic ack_o = 1'b0,
  output logic [31:0] rdata_o = 32'h0
);
  logic [7:0] mem [4096];
  logic [1:0] cnt = 2'h0;
  logic [31:0] rd;
  int n;

  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    // Stale data toggles so a late sample cannot match
    rdata_o <= ~rdata_o;
    n = 1 << bus_i.size;
    rd = 32'h0;
    if (bus_i.req && !ack_o) begin
      if (cnt < wait_i) begin
        cnt <= cnt + 2'h1;
      end else begin
        cnt <= 2'h0;
        ack_o <= 1'b1;
        for (int i = 0; i < n; i++) begin
          if (bus_i.we) mem[bus_i.addr[11:0] + 12'(i)] <= bus_i.wdata[8 * (n - 1 - i) +: 8];
          rd = {rd[23:0], mem[bus_i.addr[11:0] + 12'(i)]};
        end
        if (!bus_i.we) rdata_o <= rd;
      end
    end
  end
endmodule // ces_mem_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench
module tb_top import ces_pkg::*;;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic mode_1mb_i = 1'b0;
  logic wake_i = 1'b0;
  logic [2:0] dbg_sel_i = 3'h0;
  logic [1:0] wait_cyc = 2'h0;
  logic mem_ack_i, sleep_o, trap_o, rte_o, illegal_o;
  logic [31:0] mem_rdata_i, dbg_data_o;
  logic [23:0] pc_o;
  logic [7:0] flags_o;
  logic [15:0] n_trap, n_rte, n_ill;
  ces_bus_t mem_o;
  ces_bus_t dacc[$];
  int err_total = 0;
  int tests_run = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  ces_top u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .mem_o(mem_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .mode_1mb_i(mode_1mb_i),
    .wake_i(wake_i), .pc_o(pc_o), .flags_o(flags_o), .sleep_o(sleep_o), .trap_o(trap_o),
    .rte_o(rte_o), .illegal_o(illegal_o), .dbg_sel_i(dbg_sel_i), .dbg_data_o(dbg_data_o));
  ces_mem_model u_mem (.clk_i(sys_clk_i), .bus_i(mem_o), .wait_i(wait_cyc),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  // Data accesses only; fetches from the program page are skipped
  always @(posedge sys_clk_i) begin
    if (mem_o.req && mem_ack_i && (mem_o.we || mem_o.addr[23:8] != 16'h0001)) begin
      dacc.push_back(mem_o);
    end
    if (trap_o) n_trap++;
    if (rte_o) n_rte++;
    if (illegal_o) n_ill++;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input int i, input logic we, input ces_size_t sz, input logic [23:0] a,
      input logic [31:0] d);
    if (i >= dacc.size()) begin
      chk(32'h0, 32'h1);
    end else begin
      chk({5'h00, dacc[i].we, dacc[i].size, dacc[i].addr}, {5'h00, we, sz, a});
      if (we) chk(dacc[i].wdata & (32'hffffffff >> (6'd32 - (6'd8 << sz))), d);
    end
  endtask

  task automatic rchk(input logic [2:0] s, input logic [31:0] e);
    @(negedge sys_clk_i) dbg_sel_i = s;
    repeat (2) @(negedge sys_clk_i);
    chk(dbg_data_o, e);
  endtask

  task automatic boot(input logic [15:0] w[$], input logic [1:0] wt, input logic mb);
    @(negedge sys_clk_i) reset_i = 1'b1;
    mode_1mb_i = mb;
    wait_cyc = wt;
    foreach (u_mem.mem[i]) u_mem.mem[i] = 8'h00;
    foreach (w[i]) {u_mem.mem[256 + 2 * i], u_mem.mem[257 + 2 * i]} = w[i];
    dacc.delete();
    n_trap = 16'h0;
    n_rte = 16'h0;
    n_ill = 16'h0;
    repeat (8) @(negedge sys_clk_i);
    reset_i = 1'b0;
  endtask

  // Bounded wait for the program's closing power-down
  task automatic run();
    int n;
    n = 0;
    while (sleep_o !== 1'b1 && n < 3000) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 3000) begin
      err_total++;
      summarize();
    end
  endtask

  task automatic sc_flags();
    boot('{16'h210f, 16'h20f3, 16'h2281, 16'h6c00, 16'h0042, 16'h5c00, 16'h0040,
      16'h0000, 16'h1200}, 2'h0, 1'b0);
    {u_mem.mem[64], u_mem.mem[65]} = 16'h55aa;
    run();
    acc(0, 1'b1, SZ_WORD, 24'h000042, 32'h00000200);
    acc(1, 1'b0, SZ_WORD, 24'h000040, 32'h0);
    chk({24'h0, flags_o}, 32'h55);
    chk({8'h0, pc_o}, 32'h112);
  endtask

  task automatic sc_move();
    boot('{16'h9004, 16'h0000, 16'h0003, 16'h9005, 16'h0000, 16'h0200, 16'h9006, 16'h0000,
      16'h0301, 16'hd000, 16'hd100, 16'hb035, 16'h1200}, 2'h3, 1'b0);
    {u_mem.mem[512], u_mem.mem[513], u_mem.mem[514], u_mem.mem[515]} = 32'h11223341;
    run();
    for (int i = 0; i < 3; i++) begin
      acc(2 * i, 1'b0, SZ_BYTE, 24'h000200 + 24'(i), 32'h0);
      acc(2 * i + 1, 1'b1, SZ_BYTE, 24'h000301 + 24'(i), 32'h11 * (i + 1));
    end
    acc(6, 1'b0, SZ_BYTE, 24'h000203, 32'h0);
    acc(7, 1'b1, SZ_BYTE, 24'h000203, 32'h49);
    chk(dacc.size(), 32'h8);
    rchk(3'h4, 32'h0);
    rchk(3'h5, 32'h203);
    rchk(3'h6, 32'h304);
  endtask

  task automatic sc_ea();
    boot('{16'h9001, 16'h1234, 16'h0400, 16'h9003, 16'h0000, 16'h0506, 16'h7692, 16'h8932,
      16'h7a02, 16'h0080, 16'h7294, 16'hfffe, 16'h843c, 16'h0012, 16'h0001, 16'he104,
      16'h4111, 16'ha47c, 16'h1200}, 2'h1, 1'b1);
    {u_mem.mem[1024], u_mem.mem[1025]} = 16'hbeef;
    run();
    acc(0, 1'b0, SZ_WORD, 24'h040400, 32'h0);
    acc(1, 1'b1, SZ_LONG, 24'h000502, 32'h0000beef);
    acc(2, 1'b0, SZ_BYTE, 24'h0fff80, 32'h0);
    acc(3, 1'b0, SZ_WORD, 24'h040400, 32'h0);
    acc(4, 1'b1, SZ_BYTE, 24'h020503, 32'h000000ef);
    chk({24'h0, flags_o}, 32'h85);
    rchk(3'h1, 32'h12340402);
    rchk(3'h3, 32'h00000502);
    rchk(3'h4, 32'h00000080);
  endtask

  task automatic sc_trap();
    boot('{16'h207f, 16'hf000, 16'h1000, 16'h1200}, 2'h0, 1'b0);
    // Odd vector and a handler that stores the flags while masked
    {u_mem.mem[34], u_mem.mem[35]} = 16'h0141;
    {u_mem.mem[320], u_mem.mem[321], u_mem.mem[322]} = 24'h6c0000;
    {u_mem.mem[323], u_mem.mem[324], u_mem.mem[325]} = 24'h421100;
    run();
    acc(0, 1'b0, SZ_LONG, 24'h000020, 32'h0);
    acc(1, 1'b1, SZ_WORD, 24'h000042, 32'h00008000);
    chk({n_trap, n_rte}, 32'h00010001);
    chk({16'h0, n_ill}, 32'h00000001);
    chk({pc_o, flags_o}, 32'h00010800);
    @(negedge sys_clk_i) wake_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    chk({31'h0, sleep_o}, 32'h0);
    wake_i = 1'b0;
  endtask

  initial begin
    sc_flags();
    sc_move();
    sc_ea();
    sc_trap();
    summarize();
  end
endmodule // tb_top
